// ### hw/acs_map.vh
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// mode control register field layout
`define ACS_MODE_MSB 6
`define ACS_MODE_LSB 4
`define ACS_CLKSEL_MSB 3
`define ACS_CLKSEL_LSB 2
`define ACS_MODE_RESET 3'h0
`define ACS_CLKSEL_RESET 2'h0
// operating-mode codes
`define ACS_MODE_CONT 3'h0
`define ACS_MODE_SINGLE 3'h1
`define ACS_MODE_STANDBY 3'h2
`define ACS_MODE_PDOWN 3'h3
`define ACS_MODE_OFS_CAL 3'h6
`define ACS_MODE_GAIN_CAL 3'h7
// clock-source codes
`define ACS_CLK_INT 2'h0
`define ACS_CLK_INT_OUT 2'h1
`define ACS_CLK_EXT 2'h2
`define ACS_CLK_RSVD 2'h3
`endif

// ### hw/acs_sync3.v
`timescale 1ns/1ps
`default_nettype none
// three-stage input synchroniser; output changes once stages two and three agree
module acs_sync3 (
	input wire clk,
	input wire resetn,
	input wire din,
	output reg dout
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				dout <= s3_reg;
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/acs_cal_clk.v
// Contract
// - operating mode lives in bits [6:4] of mode control and steers the converter.
// - mode 110 runs offset calibration using present input as zero-scale.
// - offset result goes to enabled channel's offset register, then standby.
// - gain calibration uses input as full-scale, writes gain register, then standby.
// - clock source in bits [3:2], reset 00; 00 internal, 10 external, 11 reserved.
// - code 01 runs internal clock and drives it out on the clock pin.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module acs_cal_clk #(
	parameter CH_BITS = 4,
	parameter DATA_W = 24
) (
	input wire ref_clk,
	input wire resetn,
	input wire mode_wr,
	input wire [15:0] mode_wdata,
	output reg [15:0] mode_rdata,
	input wire [CH_BITS-1:0] ch_enable,
	input wire int_osc_clk,
	input wire clock_in_out_pin_in,
	output reg clock_in_out_pin_out,
	output reg clock_in_out_pin_oe,
	output reg conv_clk,
	output reg cal_start,
	output reg cal_is_gain,
	input wire cal_done,
	input wire [DATA_W-1:0] cal_result,
	output reg coef_wr,
	output reg coef_is_gain,
	output reg [CH_BITS-1:0] coef_ch,
	output reg [DATA_W-1:0] coef_data,
	output reg [2:0] active_mode,
	output reg cal_busy
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CAL = 2'h1;
	localparam ST_STORE = 2'h2;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [2:0] mode_reg;
	reg [2:0] mode_next;
	reg [1:0] clksel_reg;
	reg [1:0] clksel_next;
	reg cal_start_next;
	reg cal_is_gain_next;
	reg coef_wr_next;
	reg coef_is_gain_next;
	reg [CH_BITS-1:0] coef_ch_next;
	reg [DATA_W-1:0] coef_data_next;
	reg cal_busy_next;
	reg conv_clk_next;
	reg pin_out_next;
	reg pin_oe_next;
	wire [15:0] mode_rdata_next;
	wire [2:0] active_mode_next;
	wire [2:0] wr_mode;
	wire [1:0] wr_clksel;
	wire wr_is_cal;
	wire ext_clk_sync;
	wire osc_sync;
	reg [CH_BITS-1:0] ch_sel;
	integer i;

	acs_sync3 u_ext_sync (
		.clk(ref_clk),
		.resetn(resetn),
		.din(clock_in_out_pin_in),
		.dout(ext_clk_sync)
	);
	acs_sync3 u_osc_sync (
		.clk(ref_clk),
		.resetn(resetn),
		.din(int_osc_clk),
		.dout(osc_sync)
	);

	// lowest enabled channel; host keeps exactly one enabled during a calibration
	always @* begin
		ch_sel = {CH_BITS{1'b0}};
		for (i = CH_BITS - 1; i >= 0; i = i - 1) begin
			if (ch_enable[i]) begin
				ch_sel = i[CH_BITS-1:0];
			end
		end
	end

	assign wr_mode = mode_wdata[`ACS_MODE_MSB:`ACS_MODE_LSB];
	assign wr_clksel = mode_wdata[`ACS_CLKSEL_MSB:`ACS_CLKSEL_LSB];
	assign wr_is_cal = (wr_mode == `ACS_MODE_OFS_CAL) || (wr_mode == `ACS_MODE_GAIN_CAL);
	assign mode_rdata_next = {9'h000, mode_reg, clksel_reg, 2'h0};
	assign active_mode_next = mode_reg;

	always @* begin
		state_next = state_reg;
		mode_next = mode_reg;
		clksel_next = clksel_reg;
		cal_start_next = 1'b0;
		cal_is_gain_next = cal_is_gain;
		coef_wr_next = 1'b0;
		coef_is_gain_next = coef_is_gain;
		coef_ch_next = coef_ch;
		coef_data_next = coef_data;
		cal_busy_next = cal_busy;
		case (state_reg)
		ST_IDLE: begin
			if (mode_wr) begin
				mode_next = wr_mode;
				clksel_next = wr_clksel;
				if (wr_is_cal) begin
					cal_start_next = 1'b1;
					// bit 4 separates gain from offset calibration
					cal_is_gain_next = wr_mode[0];
					coef_ch_next = ch_sel;
					cal_busy_next = 1'b1;
					state_next = ST_CAL;
				end
			end
		end
		ST_CAL: begin
			// writes during calibration are ignored; the front end must not be disturbed
			if (cal_done) begin
				coef_data_next = cal_result;
				state_next = ST_STORE;
			end
		end
		ST_STORE: begin
			coef_wr_next = 1'b1;
			coef_is_gain_next = cal_is_gain;
			mode_next = `ACS_MODE_STANDBY;
			cal_busy_next = 1'b0;
			state_next = ST_IDLE;
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			mode_reg <= `ACS_MODE_RESET;
			clksel_reg <= `ACS_CLKSEL_RESET;
			cal_start <= 1'b0;
			cal_is_gain <= 1'b0;
			coef_wr <= 1'b0;
			coef_is_gain <= 1'b0;
			coef_ch <= {CH_BITS{1'b0}};
			coef_data <= {DATA_W{1'b0}};
			cal_busy <= 1'b0;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			clksel_reg <= clksel_next;
			cal_start <= cal_start_next;
			cal_is_gain <= cal_is_gain_next;
			coef_wr <= coef_wr_next;
			coef_is_gain <= coef_is_gain_next;
			coef_ch <= coef_ch_next;
			coef_data <= coef_data_next;
			cal_busy <= cal_busy_next;
		end
	end

	// the converter clock is a sampled level, not a glitch-free mux: only
	// sources well below ref_clk pass cleanly, traded for a single clock domain
	always @* begin
		conv_clk_next = osc_sync;
		pin_out_next = 1'b0;
		pin_oe_next = 1'b0;
		case (clksel_reg)
		`ACS_CLK_INT: begin
			conv_clk_next = osc_sync;
			pin_oe_next = 1'b0;
		end
		`ACS_CLK_INT_OUT: begin
			conv_clk_next = osc_sync;
			pin_oe_next = 1'b1;
			pin_out_next = osc_sync;
		end
		`ACS_CLK_EXT: begin
			conv_clk_next = ext_clk_sync;
			pin_oe_next = 1'b0;
		end
		default: begin
			// reserved code falls back to internal oscillator, pin released
			conv_clk_next = osc_sync;
			pin_oe_next = 1'b0;
		end
		endcase
	end

	// readback trails the mode state by one edge
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_rdata <= 16'h0000;
			active_mode <= `ACS_MODE_RESET;
		end else begin
			mode_rdata <= mode_rdata_next;
			active_mode <= active_mode_next;
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			conv_clk <= 1'b0;
			clock_in_out_pin_out <= 1'b0;
			clock_in_out_pin_oe <= 1'b0;
		end else begin
			conv_clk <= conv_clk_next;
			clock_in_out_pin_out <= pin_out_next;
			clock_in_out_pin_oe <= pin_oe_next;
		end
	end
endmodule
`default_nettype wire

// ### dv/acs_cal_clk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acs_cal_clk_asserts #(parameter DATA_W = 24) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic mode_wr,
	input wire logic [15:0] mode_wdata,
	input wire logic [15:0] mode_rdata,
	input wire logic clock_in_out_pin_oe,
	input wire logic cal_start,
	input wire logic cal_is_gain,
	input wire logic cal_done,
	input wire logic [DATA_W-1:0] cal_result,
	input wire logic coef_wr,
	input wire logic coef_is_gain,
	input wire logic [DATA_W-1:0] coef_data,
	input wire logic [2:0] active_mode,
	input wire logic cal_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire logic go = mode_wr && !cal_busy;
	mode_apply_a: assert property (go && mode_wdata[6:5] != 2'h3 |-> ##2 active_mode == $past(mode_wdata[6:4], 2))
		else $error("mode not applied");
	ofs_start_a: assert property (go && mode_wdata[6:4] == 3'h6 |=> cal_start && !cal_is_gain && cal_busy)
		else $error("offset cal not started");
	gain_start_a: assert property (go && mode_wdata[6:4] == 3'h7 |=> cal_start && cal_is_gain)
		else $error("gain cal not started");
	coef_store_a: assert property (cal_busy && cal_done |-> ##2 coef_wr
		&& coef_data == $past(cal_result, 2) && coef_is_gain == $past(cal_is_gain, 2))
		else $error("coefficient not stored");
	to_standby_a: assert property (cal_busy && cal_done |-> ##2 !cal_busy ##1 active_mode == 3'h2)
		else $error("no standby after cal");
	// stable guard: oe and readback update on the same edge
	pin_drive_a: assert property (mode_rdata[3:2] == 2'h1 && $stable(mode_rdata) |-> clock_in_out_pin_oe)
		else $error("pin not driven");
	pin_idle_a: assert property (mode_rdata[3:2] != 2'h1 && $stable(mode_rdata) |-> !clock_in_out_pin_oe)
		else $error("pin driven");
	cover property (coef_wr && coef_is_gain);
	cover property (coef_wr && !coef_is_gain);
	cover property (clock_in_out_pin_oe);
endmodule
`default_nettype wire

// ### dv/tb_acs_cal_clk.sv
`timescale 1ns/1ps
`default_nettype none
module tb_acs_cal_clk;
	logic ref_clk = 0, resetn = 0, mode_wr = 0, osc = 0, pin_in = 0, cal_done = 0;
	logic [15:0] wdata = 16'h0000;
	logic [3:0] ch_en = 4'h1;
	logic [23:0] res = 24'h000000;
	logic [31:0] rs = 32'h0000cc72;
	wire [15:0] rdata;
	wire pin_out, oe, conv_clk, cal_start, cal_is_gain, coef_wr, coef_is_gain, cal_busy;
	wire [3:0] coef_ch;
	wire [23:0] coef_data;
	wire [2:0] active_mode;
	int error_cnt = 0, cmp_count = 0;
	always #4 ref_clk = ~ref_clk;
	acs_cal_clk i_acs_cal_clk (.ref_clk(ref_clk), .resetn(resetn), .mode_wr(mode_wr), .mode_wdata(wdata),
		.mode_rdata(rdata), .ch_enable(ch_en), .int_osc_clk(osc), .clock_in_out_pin_in(pin_in),
		.clock_in_out_pin_out(pin_out), .clock_in_out_pin_oe(oe), .conv_clk(conv_clk), .cal_start(cal_start),
		.cal_is_gain(cal_is_gain), .cal_done(cal_done), .cal_result(res), .coef_wr(coef_wr),
		.coef_is_gain(coef_is_gain), .coef_ch(coef_ch), .coef_data(coef_data), .active_mode(active_mode),
		.cal_busy(cal_busy));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic exp_conv(input logic [1:0] s);
		return s == 2'h2 ? pin_in : osc;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [15:0] d);
		@(posedge ref_clk);
		mode_wr <= 1'h1;
		wdata <= d;
		@(posedge ref_clk);
		mode_wr <= 1'h0;
		#1;
	endtask
	task automatic ck(input logic [1:0] s);
		logic [2:0] m;
		rs = xs(rs);
		m = rs[4:2] & (rs[4] ? 3'h5 : 3'h7);
		@(posedge ref_clk);
		osc <= rs[0];
		pin_in <= rs[1];
		wr({9'h0, m, s, 2'h0});
		repeat (8) @(posedge ref_clk);
		#1;
		chk("word", rdata, {9'h0, m, s, 2'h0});
		chk("oe", oe, s == 2'h1);
		chk("conv", conv_clk, exp_conv(s));
		chk("pin", pin_out, s == 2'h1 ? osc : 1'h0);
	endtask
	task automatic cal(input logic [2:0] m);
		logic [1:0] c;
		rs = xs(rs);
		c = rs[1:0];
		@(posedge ref_clk);
		ch_en <= 4'h1 << c;
		res <= rs[31:8];
		wr({9'h0, m, 4'h0});
		chk("start", {cal_start, cal_busy, cal_is_gain}, {2'h3, m[0]});
		// a write while busy must be dropped; its clock code would show in the readback
		@(posedge ref_clk);
		mode_wr <= 1'h1;
		wdata <= 16'h0004;
		cal_done <= 1'h1;
		@(posedge ref_clk);
		mode_wr <= 1'h0;
		cal_done <= 1'h0;
		@(posedge ref_clk);
		#1;
		chk("coef", {coef_wr, coef_is_gain, coef_ch, coef_data}, {1'b1, m[0], 2'h0, c, res});
		@(posedge ref_clk);
		#1;
		chk("stby", {cal_busy, active_mode, rdata}, {4'h2, 16'h0020});
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1;
		#1;
		chk("rst", {oe, rdata}, 17'h00000);
		for (int i = 0; i < 12; i++) ck(i[1:0]);
		for (int i = 0; i < 4; i++) cal({2'h3, i[0]});
		close_out();
	end
endmodule
bind acs_cal_clk acs_cal_clk_asserts #(.DATA_W(DATA_W)) i_acs_cal_clk_asserts (.ref_clk, .resetn, .mode_wr,
	.mode_wdata, .mode_rdata, .clock_in_out_pin_oe, .cal_start, .cal_is_gain, .cal_done, .cal_result, .coef_wr,
	.coef_is_gain, .coef_data, .active_mode, .cal_busy);
`default_nettype wire
